// ===== adcf_pkg.sv
// Shared constants and types of the converter control block
package adcf_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADCF_OFS_REF   = 8'h00;
  localparam logic [7:0] ADCF_OFS_FTC   = 8'h04;
  localparam logic [7:0] ADCF_OFS_RES_H = 8'h08;
  localparam logic [7:0] ADCF_OFS_RES_L = 8'h0C;
  localparam logic [7:0] ADCF_OFS_CTRL  = 8'h10;
  localparam logic [7:0] ADCF_OFS_STAT  = 8'h14;
  localparam logic [7:0] ADCF_OFS_CLR   = 8'h18;
  localparam logic [7:0] ADCF_OFS_IEN   = 8'h1C;

  // Field positions
  localparam int ADCF_POS_PREF    = 2;
  localparam int ADCF_POS_JUSTIFY = 7;
  localparam int ADCF_POS_ACQ     = 3;
  localparam int ADCF_POS_CLK     = 0;
  localparam int ADCF_POS_ENABLE  = 0;
  localparam int ADCF_POS_START   = 1;
  localparam int ADCF_POS_DONE    = 0;
  localparam int ADCF_POS_ABORT   = 1;

  // Values after reset
  localparam logic [7:0] ADCF_RST_BYTE = 8'h00;
  localparam logic [1:0] ADCF_RST_INT  = 2'h0;

  // Reference codes
  localparam logic [1:0] ADCF_REF_RAIL  = 2'h0;
  localparam logic [1:0] ADCF_REF_PIN   = 2'h1;
  localparam logic [1:0] ADCF_REF_FIXED = 2'h2;

  // Timing: core clock, one instruction is four core clocks
  localparam int CLK_PERIOD_NS  = 25;
  localparam int INSTR_TIME_NS  = 100;
  localparam int START_DLY_CYC  = (INSTR_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [4:0] ADCF_WAIT_TADS = 5'h02;
  localparam int ADCF_RES_W = 10;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_ACQ, ST_CONV, ST_WAIT
  } adcf_state_type;

endpackage

// ===== adcf_ctrl.sv
// Converter control, timing and result formatting with a Wishbone slave
`timescale 1ns/1ps

// Summary of operation
// - Positive reference: 00 rail, 01 external pin, 10 fixed, 11 reserved.
// - Negative reference code 00 ground, 01 external pin; 10, 11 reserved.
// - Format bit 7 set gives right justification, clear gives left.
// - Acquisition field bits 5-3 gives 0,2,4,6,8,12,16,20 clock periods.
// - Hold capacitor stays on channel from start bit until conversion begins.
// - Clock field bits 2-0: /2,/8,/32,RC,/4,/16,/64,RC.
// - With RC clock, conversion start waits one instruction after start bit.
// - Left justified: high byte holds result bits 9 to 2.
// - Left justified: low byte bits 7-6 hold result 1-0, rest zero.
// - Right justified: high byte bits 1-0 hold result 9-8, rest zero.
// - Right justified: low byte holds result bits 7 to 0.
// - Unimplemented bits of reference and format registers read zero.
// - Hold capacitor is discharged after every conversion.
// - On completion clear start bit, set done flag, load result bytes.
// - After completion or abort wait two clock periods before reconnecting.
module adcf_ctrl
  import adcf_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic        rc_tick_in,
  input  wire logic        cmp_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out,
  output logic      [2:0]  pos_ref_out,
  output logic      [1:0]  neg_ref_out,
  output logic             hold_connect_out,
  output logic             hold_discharge_out,
  output logic             converting_out,
  output logic      [9:0]  dac_code_out
);

  adcf_state_type   state;
  logic [1:0]       positive_ref_field;
  logic [1:0]       negative_ref_field;
  logic             justify_select;
  logic [2:0]       acquisition_delay_field;
  logic [2:0]       conversion_clock_field;
  logic             enable;
  logic             start;
  logic [7:0]       result_high_byte;
  logic [7:0]       result_low_byte;
  logic [1:0]       int_status;
  logic [1:0]       int_enable;
  logic [6:0]       div_cnt;
  logic [6:0]       div_end;
  logic             core_tick;
  logic             tad_tick;
  logic             rc_mode;
  logic [4:0]       acq_len;
  logic [4:0]       cnt;
  logic [9:0]       sar;
  logic [3:0]       idx;
  logic             last_bit;
  logic             any_done;
  logic             load_req;
  logic [9:0]       load_val;
  logic             done_ev;
  logic             abort_ev;
  logic             hw_clear_start;
  logic             req;
  logic             wr;
  logic             stop;
  logic [9:0]       fill_res;
  logic [31:0]      next_rdata;

  // Bus request and write qualifier; write lands at the ack edge
  assign req = wb_cyc_in & wb_stb_in;
  assign wr  = req & wb_we_in & wb_ack_out & wb_sel_in[0];

  // Clock divider select, RC codes use the oscillator tick
  assign rc_mode = (conversion_clock_field[1:0] == 2'h3);
  always_comb begin
    case (conversion_clock_field)
      3'h0:    div_end = 7'h01;
      3'h1:    div_end = 7'h07;
      3'h2:    div_end = 7'h1F;
      3'h4:    div_end = 7'h03;
      3'h5:    div_end = 7'h0F;
      3'h6:    div_end = 7'h3F;
      default: div_end = 7'h01;
    endcase
  end

  // Acquisition length in conversion clock periods
  always_comb begin
    case (acquisition_delay_field)
      3'h0:    acq_len = 5'h00;
      3'h1:    acq_len = 5'h02;
      3'h2:    acq_len = 5'h04;
      3'h3:    acq_len = 5'h06;
      3'h4:    acq_len = 5'h08;
      3'h5:    acq_len = 5'h0C;
      3'h6:    acq_len = 5'h10;
      default: acq_len = 5'h14;
    endcase
  end

  // Free running divider; first period after a start may be short
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= 7'h00;
    end else if (core_tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  assign core_tick = (div_cnt >= div_end);
  assign tad_tick  = rc_mode ? rc_tick_in : core_tick;

  // Abort when software drops start or enable while busy
  assign stop = ~start | ~enable;

  // Partial result: undecided bits copy the last decided bit
  genvar gi;
  generate
    for (gi = 0; gi < ADCF_RES_W; gi = gi + 1) begin : g_fill
      assign fill_res[gi] = (gi <= idx) ? (any_done & last_bit)
                                        : sar[gi];
    end
  endgenerate

  // Sequencer: delay, acquisition, conversion, discharge wait
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state          <= ST_IDLE;
      cnt            <= 5'h00;
      sar            <= 10'h000;
      idx            <= 4'h0;
      last_bit       <= 1'b0;
      any_done       <= 1'b0;
      load_req       <= 1'b0;
      load_val       <= 10'h000;
      done_ev        <= 1'b0;
      abort_ev       <= 1'b0;
      hw_clear_start <= 1'b0;
    end else begin
      load_req       <= 1'b0;
      done_ev        <= 1'b0;
      abort_ev       <= 1'b0;
      hw_clear_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start && enable && !hw_clear_start) begin
            if (rc_mode) begin
              state <= ST_START;
              cnt   <= 5'(START_DLY_CYC - 1);
            end else if (acq_len == 5'h00) begin
              state    <= ST_CONV;
              sar      <= 10'h200;
              idx      <= 4'h9;
              any_done <= 1'b0;
            end else begin
              state <= ST_ACQ;
              cnt   <= acq_len;
            end
          end
        end
        ST_START: begin
          if (stop) begin
            state    <= ST_WAIT;
            cnt      <= ADCF_WAIT_TADS;
            abort_ev <= 1'b1;
          end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
          end else if (acq_len == 5'h00) begin
            state    <= ST_CONV;
            sar      <= 10'h200;
            idx      <= 4'h9;
            any_done <= 1'b0;
          end else begin
            state <= ST_ACQ;
            cnt   <= acq_len;
          end
        end
        ST_ACQ: begin
          if (stop) begin
            state    <= ST_WAIT;
            cnt      <= ADCF_WAIT_TADS;
            abort_ev <= 1'b1;
          end else if (tad_tick) begin
            if (cnt == 5'h01) begin
              state    <= ST_CONV;
              sar      <= 10'h200;
              idx      <= 4'h9;
              any_done <= 1'b0;
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (stop) begin
            // Partial sample still goes to the result bytes
            state    <= ST_WAIT;
            cnt      <= ADCF_WAIT_TADS;
            load_req <= 1'b1;
            load_val <= fill_res;
            abort_ev <= 1'b1;
          end else if (tad_tick && dac_code_out == sar) begin
            // Trial code output lags one cycle; never judge a stale code
            sar[idx] <= cmp_in;
            last_bit <= cmp_in;
            any_done <= 1'b1;
            if (idx == 4'h0) begin
              state          <= ST_WAIT;
              cnt            <= ADCF_WAIT_TADS;
              load_req       <= 1'b1;
              load_val       <= {sar[9:1], cmp_in};
              done_ev        <= 1'b1;
              hw_clear_start <= 1'b1;
            end else begin
              sar[idx - 4'h1] <= 1'b1;
              idx             <= idx - 4'h1;
            end
          end
        end
        ST_WAIT: begin
          if (tad_tick) begin
            if (cnt <= 5'h01) begin
              state <= ST_IDLE;
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration registers; reserved reference codes are stored as written
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      positive_ref_field      <= 2'h0;
      negative_ref_field      <= 2'h0;
      justify_select          <= 1'b0;
      acquisition_delay_field <= 3'h0;
      conversion_clock_field  <= 3'h0;
    end else if (wr && wb_adr_in == ADCF_OFS_REF) begin
      positive_ref_field <= wb_dat_in[ADCF_POS_PREF +: 2];
      negative_ref_field <= wb_dat_in[1:0];
    end else if (wr && wb_adr_in == ADCF_OFS_FTC) begin
      justify_select          <= wb_dat_in[ADCF_POS_JUSTIFY];
      acquisition_delay_field <= wb_dat_in[ADCF_POS_ACQ +: 3];
      conversion_clock_field  <= wb_dat_in[ADCF_POS_CLK +: 3];
    end
  end

  // Control: hardware clear of start beats a same cycle write
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable <= 1'b0;
      start  <= 1'b0;
    end else begin
      if (wr && wb_adr_in == ADCF_OFS_CTRL) begin
        enable <= wb_dat_in[ADCF_POS_ENABLE];
        start  <= wb_dat_in[ADCF_POS_START];
      end
      if (hw_clear_start) begin
        start <= 1'b0;
      end
    end
  end

  // Result bytes: conversion load wins over a software write
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_high_byte <= ADCF_RST_BYTE;
      result_low_byte  <= ADCF_RST_BYTE;
    end else if (load_req) begin
      if (justify_select) begin
        result_high_byte <= {6'h00, load_val[9:8]};
        result_low_byte  <= load_val[7:0];
      end else begin
        result_high_byte <= load_val[9:2];
        result_low_byte  <= {load_val[1:0], 6'h00};
      end
    end else if (wr && wb_adr_in == ADCF_OFS_RES_H) begin
      result_high_byte <= wb_dat_in[7:0];
    end else if (wr && wb_adr_in == ADCF_OFS_RES_L) begin
      result_low_byte <= wb_dat_in[7:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_status <= ADCF_RST_INT;
      int_enable <= ADCF_RST_INT;
    end else begin
      int_status <= (int_status
                     & ~((wr && wb_adr_in == ADCF_OFS_CLR)
                         ? wb_dat_in[1:0] : 2'h0))
                    | {abort_ev, done_ev};
      if (wr && wb_adr_in == ADCF_OFS_IEN) begin
        int_enable <= wb_dat_in[1:0];
      end
    end
  end

  // Read mux; unimplemented bits and unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_in)
      ADCF_OFS_REF: begin
        next_rdata[3:0] = {positive_ref_field, negative_ref_field};
      end
      ADCF_OFS_FTC: begin
        next_rdata[7:0] = {justify_select, 1'b0,
                           acquisition_delay_field,
                           conversion_clock_field};
      end
      ADCF_OFS_RES_H: next_rdata[7:0] = result_high_byte;
      ADCF_OFS_RES_L: next_rdata[7:0] = result_low_byte;
      ADCF_OFS_CTRL:  next_rdata[1:0] = {start, enable};
      ADCF_OFS_STAT:  next_rdata[1:0] = int_status;
      ADCF_OFS_IEN:   next_rdata[1:0] = int_enable;
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state ack, dropped the cycle after it was given
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req & ~wb_ack_out;
      if (req && !wb_ack_out) begin
        wb_dat_out <= next_rdata;
      end
    end
  end

  // Analog steering outputs, reserved codes select nothing
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_ref_out <= 3'h0;
      neg_ref_out <= 2'h0;
    end else begin
      pos_ref_out <= {positive_ref_field == ADCF_REF_FIXED,
                      positive_ref_field == ADCF_REF_PIN,
                      positive_ref_field == ADCF_REF_RAIL};
      neg_ref_out <= {negative_ref_field == ADCF_REF_PIN,
                      negative_ref_field == ADCF_REF_RAIL};
    end
  end

  // Hold switch, discharge, trial code and interrupt level
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_connect_out   <= 1'b0;
      hold_discharge_out <= 1'b0;
      converting_out     <= 1'b0;
      dac_code_out       <= 10'h000;
      irq_out            <= 1'b0;
    end else begin
      hold_connect_out   <= (state == ST_IDLE) | (state == ST_START)
                            | (state == ST_ACQ);
      hold_discharge_out <= (state == ST_WAIT);
      converting_out     <= (state == ST_CONV);
      dac_code_out       <= sar;
      irq_out            <= |(int_status & int_enable);
    end
  end

endmodule // adcf_ctrl

// ===== adcf_ctrl_asserts.sv
// Port level checks of the converter control block
`timescale 1ns/1ps
module adcf_ctrl_chk
  import adcf_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  input  wire logic [2:0]  pos_ref_out,
  input  wire logic [1:0]  neg_ref_out,
  input  wire logic        hold_connect_out,
  input  wire logic        hold_discharge_out,
  input  wire logic        converting_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Read answer, master still holds the address
  logic rd_ack;
  assign rd_ack = wb_ack_out && !wb_we_in;

  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_ANSWER: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered next cycle");
  AST_REF_ZERO: assert property (
    rd_ack && wb_adr_in == ADCF_OFS_REF |-> wb_dat_out[7:4] == 4'h0)
    else $error("reference register upper bits not zero");
  AST_FTC_ZERO: assert property (
    rd_ack && wb_adr_in == ADCF_OFS_FTC |-> !wb_dat_out[6])
    else $error("format register bit 6 not zero");
  AST_POS_ONEHOT: assert property ($onehot0(pos_ref_out))
    else $error("several positive references at once");
  AST_NEG_ONEHOT: assert property ($onehot0(neg_ref_out))
    else $error("several negative references at once");
  // Channel never touches a capacitor being converted or emptied
  AST_HOLD_EXCL: assert property (
    !(hold_connect_out && (converting_out || hold_discharge_out)))
    else $error("hold connected outside acquisition");
  AST_DISCH_AFTER: assert property (
    $fell(converting_out) |-> hold_discharge_out)
    else $error("no discharge after conversion");
  AST_DISCH_MIN: assert property (
    $rose(hold_discharge_out) |-> hold_discharge_out [*2])
    else $error("post conversion wait too short");
  AST_DISCH_END: assert property (
    $rose(hold_discharge_out) |-> ##[2:200] !hold_discharge_out)
    else $error("post conversion wait never ends");
endmodule // adcf_ctrl_chk

bind adcf_ctrl adcf_ctrl_chk u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .pos_ref_out(pos_ref_out), .neg_ref_out(neg_ref_out),
  .hold_connect_out(hold_connect_out),
  .hold_discharge_out(hold_discharge_out),
  .converting_out(converting_out)
);

// ===== adcf_analog_model.sv
// Comparator and RC oscillator around the converter control block
`timescale 1ns/1ps
module adcf_analog_model #(
  parameter int RC_DIV = 16
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [9:0] dac_code_in,
  input  wire logic [9:0] level_in,
  output logic            cmp_out,
  output logic            rc_tick_out
);
  int unsigned rc_cnt;

  // Free running oscillator, unrelated to conversion starts
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rc_cnt      <= 0;
      rc_tick_out <= 1'b0;
    end else begin
      rc_cnt      <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
      rc_tick_out <= (rc_cnt == RC_DIV - 1);
    end
  end

  // Ideal comparator, no offset so the result equals the level
  assign cmp_out = (level_in >= dac_code_in);
endmodule // adcf_analog_model

// ===== test_adc_config_result_format.sv
// Register level test of the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_adc_config_result_format;
  import adcf_pkg::*;
  localparam int         RC_DIV      = 16;
  localparam logic [2:0] POS_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  localparam logic [1:0] NEG_TAB [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  localparam int         DIV_TAB [8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
  localparam int         ACQ_TAB [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  localparam logic [7:0] FTC_TAB [9] = '{8'h00, 8'h89, 8'h12, 8'h9B,
                                        8'h24, 8'hAD, 8'h36, 8'hBF, 8'h03};
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [31:0] wb_wdat  = 32'h0;
  logic [9:0]  level    = 10'h000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        rc_tick;
  logic        cmp;
  logic        irq;
  logic [2:0]  pos_ref;
  logic [1:0]  neg_ref;
  logic        hold_c;
  logic        hold_d;
  logic        conv;
  logic [9:0]  dac;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cyc_cnt    = 0;

  adcf_ctrl dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_dat_in(wb_wdat), .wb_sel_in(4'hF), .rc_tick_in(rc_tick),
    .cmp_in(cmp), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .irq_out(irq), .pos_ref_out(pos_ref), .neg_ref_out(neg_ref),
    .hold_connect_out(hold_c), .hold_discharge_out(hold_d),
    .converting_out(conv), .dac_code_out(dac));
  adcf_analog_model #(.RC_DIV(RC_DIV)) u_analog (
    .core_clk_in(clk), .rst_n_in(rst_n), .dac_code_in(dac),
    .level_in(level), .cmp_out(cmp), .rc_tick_out(rc_tick));

  always #12.5 clk = ~clk;

  // Longest run is some 4500 cycles, so this only cuts a hang
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= {24'h000000, d};
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_rdat[7:0];
    wb_cyc  <= 1'b0;
    wb_stb  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    `CHK(nm, e, q)
  endtask

  initial begin
    logic [9:0] lv;
    logic       rj;
    int         n;
    int         d;
    int         na;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unimplemented bits, unmapped place
    rd_chk("ref reset", ADCF_OFS_REF, ADCF_RST_BYTE);
    wr(ADCF_OFS_REF, 8'hFF);
    rd_chk("ref ones", ADCF_OFS_REF, 8'h0F);
    wr(ADCF_OFS_FTC, 8'hFF);
    rd_chk("ftc ones", ADCF_OFS_FTC, 8'hBF);
    rd_chk("unmapped", 8'h40, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(ADCF_OFS_REF, 8'(i));
      repeat (3) @(posedge clk);
      `CHK("pos ref", POS_TAB[i[3:2]], pos_ref)
      `CHK("neg ref", NEG_TAB[i[1:0]], neg_ref)
    end
    // Every delay, clock and both formats; odd runs masked
    wr(ADCF_OFS_CTRL, 8'h01);
    for (int i = 0; i < 9; i++) begin
      lv = 10'h0C5 + 10'(i * 83);
      rj = FTC_TAB[i][7];
      d = DIV_TAB[FTC_TAB[i][2:0]];
      na = ACQ_TAB[FTC_TAB[i][5:3]];
      level <= lv;
      wr(ADCF_OFS_FTC, FTC_TAB[i]);
      wr(ADCF_OFS_IEN, {7'h00, ~rj});
      repeat (8) @(posedge clk);
      wr(ADCF_OFS_CTRL, 8'h03);
      repeat (3) @(posedge clk);
      if (na == 0) `CHK("early start", (d != RC_DIV), conv)
      for (n = 3; conv !== 1'b1; n++) @(posedge clk);
      `CHK("acq low", 1'b1, n >= (na > 0 ? (na - 1) * d : 0))
      `CHK("acq high", 1'b1, n <= na * d + 8)
      for (n = 0; conv === 1'b1; n++) @(posedge clk);
      `CHK("conv low", 1'b1, n >= 9 * d)
      `CHK("conv high", 1'b1, n <= 10 * d + 2)
      repeat (2) @(posedge clk);
      rd_chk("done", ADCF_OFS_STAT, 8'h01);
      rd_chk("start cleared", ADCF_OFS_CTRL, 8'h01);
      `CHK("irq", ~rj, irq)
      rd_chk("high", ADCF_OFS_RES_H,
             rj ? {6'h00, lv[9:8]} : lv[9:2]);
      rd_chk("low", ADCF_OFS_RES_L,
             rj ? lv[7:0] : {lv[1:0], 6'h00});
      wr(ADCF_OFS_CLR, 8'h03);
      rd_chk("cleared", ADCF_OFS_STAT, 8'h00);
      `CHK("irq off", 1'b0, irq)
      while (hold_c !== 1'b1) @(posedge clk);
    end
    // Abort in mid conversion, then the wait before reconnecting
    wr(ADCF_OFS_FTC, 8'h02);
    wr(ADCF_OFS_CTRL, 8'h03);
    while (conv !== 1'b1) @(posedge clk);
    repeat (40) @(posedge clk);
    wr(ADCF_OFS_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("discharge", 1'b1, hold_d)
    `CHK("no reconnect", 1'b0, hold_c)
    rd_chk("abort", ADCF_OFS_STAT, 8'h02);
    // Two divide by 32 periods must pass before the channel is back
    for (n = 0; hold_c !== 1'b1 && n < 200; n++) @(posedge clk);
    `CHK("reconnect", 1'b1, n >= 26 && n <= 64)
    summarize();
  end
endmodule // test_adc_config_result_format
